// ==== src/gpio_ports_with_aux_input.sv ====
// gpio_ports_with_aux_input: apb gpio ports with
// per-pin drive select and an auxiliary input port.
// assumes one clock; pins async, modes synchronous.
//
// Function
// - eight-pin port and two-pin port provided
// - data reads return sampled pin levels
// - data writes latch outgoing pin values
// - each pin decoded from own bits only
// - reset clears data and selects, pins hi-z
// - both selects zero gives high impedance
// - hi set, lo clear, data low: low sink
// - lo set, hi clear, data low: medium sink
// - both selects set, data low: high sink
// - lo set, data high: driven high
// - hi set, lo clear, data high: resistor pullup
// - ttl only when undriven with data high
// - four write-only select registers, consecutive
// - narrow port keeps only bits one, zero
// - read-only auxiliary input port register
// - aux bits five, four show usb lines
// - aux bit two shows crystal out pin
// - aux bit one shows crystal in pin
// - aux bit zero shows regulator pin
// - every gpio pin usable as interrupt source
`timescale 1ns/1ps
module gpio_ports_with_aux_input #(
    parameter int WIDE_W   = gpio_pkg::WIDE_PINS,
    parameter int NARROW_W = gpio_pkg::NARROW_PINS
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // eight-pin port
    input  wire logic [WIDE_W-1:0]   wide_port_pins_in,
    output logic      [WIDE_W-1:0]   wide_port_pins_out,
    output logic      [WIDE_W-1:0]   wide_port_pins_oe_n,
    output gpio_pkg::pin_ctrl_s [WIDE_W-1:0] wide_port_ctrl,
    output logic      [WIDE_W-1:0]   wide_port_levels,
    // two-pin port
    input  wire logic [NARROW_W-1:0] narrow_port_pins_in,
    output logic      [NARROW_W-1:0] narrow_port_pins_out,
    output logic      [NARROW_W-1:0] narrow_port_pins_oe_n,
    output gpio_pkg::pin_ctrl_s [NARROW_W-1:0] narrow_port_ctrl,
    output logic      [NARROW_W-1:0] narrow_port_levels,
    // auxiliary inputs
    input  wire logic                usb_dplus_pin,
    input  wire logic                usb_dminus_pin,
    input  wire logic                crystal_out_pin,
    input  wire logic                crystal_in_pin,
    input  wire logic                regulator_pin,
    input  wire logic                internal_clock_mode,
    input  wire logic                ps2_mode
);

    // software-written state
    logic [WIDE_W-1:0]   wide_data_reg;
    logic [NARROW_W-1:0] narrow_data_reg;
    logic [WIDE_W-1:0]   wide_sel_lo_reg;
    logic [WIDE_W-1:0]   wide_sel_hi_reg;
    logic [NARROW_W-1:0] narrow_sel_lo_reg;
    logic [NARROW_W-1:0] narrow_sel_hi_reg;

    // read path
    logic [31:0]         prdata_reg;
    logic                pslverr_reg;
    logic [31:0]         read_value;
    logic                addr_mapped;

    // synchronised pin levels
    logic [gpio_pkg::AUX_BITS-1:0] aux_raw;
    logic [gpio_pkg::AUX_BITS-1:0] aux_level;
    logic [7:0]          aux_value;

    // bus decode
    logic                setup_phase;
    logic                write_access;
    logic                word_aligned;
    logic [5:0]          reg_index;
    logic                hit_wide_data;
    logic                hit_narrow_data;
    logic                hit_aux;
    logic                hit_wide_lo;
    logic                hit_wide_hi;
    logic                hit_narrow_lo;
    logic                hit_narrow_hi;

    // zero wait states: every access completes in its first access cycle
    assign pready       = 1'b1;
    assign setup_phase  = psel && !penable;
    assign write_access = psel && penable && pwrite && clk_en;

    // the index is the word address; low two address bits must be zero
    assign word_aligned = (paddr[1:0] == 2'b00);
    assign reg_index    = paddr[7:2];

    assign hit_wide_data   = word_aligned && (reg_index == gpio_pkg::WIDE_DATA_IDX[5:0]);
    assign hit_narrow_data = word_aligned && (reg_index == gpio_pkg::NARROW_DATA_IDX[5:0]);
    assign hit_aux         = word_aligned && (reg_index == gpio_pkg::AUX_INPUT_IDX[5:0]);
    assign hit_wide_lo     = word_aligned && (reg_index == gpio_pkg::WIDE_SEL_LO_IDX[5:0]);
    assign hit_wide_hi     = word_aligned && (reg_index == gpio_pkg::WIDE_SEL_HI_IDX[5:0]);
    assign hit_narrow_lo   = word_aligned && (reg_index == gpio_pkg::NARROW_SEL_LO_IDX[5:0]);
    assign hit_narrow_hi   = word_aligned && (reg_index == gpio_pkg::NARROW_SEL_HI_IDX[5:0]);

    assign addr_mapped = hit_wide_data || hit_narrow_data || hit_aux
                       || hit_wide_lo || hit_wide_hi || hit_narrow_lo || hit_narrow_hi;

    // aux port samples; bit order follows the register layout
    assign aux_raw[gpio_pkg::AUX_DPLUS_BIT]    = usb_dplus_pin;
    assign aux_raw[gpio_pkg::AUX_DMINUS_BIT]   = usb_dminus_pin;
    assign aux_raw[3]                          = 1'b0;
    assign aux_raw[gpio_pkg::AUX_XTAL_OUT_BIT] = crystal_out_pin;
    assign aux_raw[gpio_pkg::AUX_XTAL_IN_BIT]  = crystal_in_pin;
    assign aux_raw[gpio_pkg::AUX_REG_PIN_BIT]  = regulator_pin;

    // all pin inputs pass three flops before anything looks at them
    pin_level_sync #(
        .WIDTH (WIDE_W)
    ) u_wide_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (wide_port_pins_in),
        .level    (wide_port_levels)   // also feeds outside interrupt logic
    );

    pin_level_sync #(
        .WIDTH (NARROW_W)
    ) u_narrow_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (narrow_port_pins_in),
        .level    (narrow_port_levels)
    );

    pin_level_sync #(
        .WIDTH (gpio_pkg::AUX_BITS)
    ) u_aux_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (aux_raw),
        .level    (aux_level)
    );

    // crystal bits read zero outside internal clock mode,
    // the regulator bit outside ps2 mode
    assign aux_value[7:6] = 2'b00;
    assign aux_value[gpio_pkg::AUX_DPLUS_BIT]  = aux_level[gpio_pkg::AUX_DPLUS_BIT];
    assign aux_value[gpio_pkg::AUX_DMINUS_BIT] = aux_level[gpio_pkg::AUX_DMINUS_BIT];
    assign aux_value[3] = 1'b0;
    assign aux_value[gpio_pkg::AUX_XTAL_OUT_BIT] =
        internal_clock_mode && aux_level[gpio_pkg::AUX_XTAL_OUT_BIT];
    assign aux_value[gpio_pkg::AUX_XTAL_IN_BIT] =
        internal_clock_mode && aux_level[gpio_pkg::AUX_XTAL_IN_BIT];
    assign aux_value[gpio_pkg::AUX_REG_PIN_BIT] =
        ps2_mode && aux_level[gpio_pkg::AUX_REG_PIN_BIT];

    // read mux: data registers return pin levels, never the stored values;
    // select registers are write-only and read as zero
    assign read_value =
          hit_wide_data   ? {{(32-WIDE_W){1'b0}}, wide_port_levels}
        : hit_narrow_data ? {{(32-NARROW_W){1'b0}}, narrow_port_levels}
        : hit_aux         ? {24'h000000, aux_value}
        : 32'h00000000;

    // read data captured at setup so it stands in flops
    // through the access cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else if (clk_en && setup_phase)
        begin
            prdata_reg  <= pwrite ? 32'h00000000 : read_value;
            pslverr_reg <= !addr_mapped;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;

    // eight-pin port data: one bit per pin, written in the access cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wide_data_reg <= gpio_pkg::DATA_RESET[WIDE_W-1:0];
        end
        else if (write_access && hit_wide_data)
        begin
            wide_data_reg <= pwdata[WIDE_W-1:0];
        end
    end

    // two-pin port data: upper bits of the write are dropped
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            narrow_data_reg <= gpio_pkg::DATA_RESET[NARROW_W-1:0];
        end
        else if (write_access && hit_narrow_data)
        begin
            narrow_data_reg <= pwdata[NARROW_W-1:0];
        end
    end

    // eight-pin drive selects at consecutive indices
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wide_sel_lo_reg <= gpio_pkg::SEL_RESET[WIDE_W-1:0];
            wide_sel_hi_reg <= gpio_pkg::SEL_RESET[WIDE_W-1:0];
        end
        else if (write_access)
        begin
            if (hit_wide_lo)
            begin
                wide_sel_lo_reg <= pwdata[WIDE_W-1:0];
            end
            if (hit_wide_hi)
            begin
                wide_sel_hi_reg <= pwdata[WIDE_W-1:0];
            end
        end
    end

    // two-pin drive selects; only the low two bits exist
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            narrow_sel_lo_reg <= gpio_pkg::SEL_RESET[NARROW_W-1:0];
            narrow_sel_hi_reg <= gpio_pkg::SEL_RESET[NARROW_W-1:0];
        end
        else if (write_access)
        begin
            if (hit_narrow_lo)
            begin
                narrow_sel_lo_reg <= pwdata[NARROW_W-1:0];
            end
            if (hit_narrow_hi)
            begin
                narrow_sel_hi_reg <= pwdata[NARROW_W-1:0];
            end
        end
    end

    // one decoder per pin, fed by its own bits; open drain
    // means toggling lo alone with data and hi low
    genvar w;
    generate
        for (w = 0; w < WIDE_W; w++)
        begin : g_wide
            gpio_pin_drive u_drive (
                .ref_clk      (ref_clk),
                .reset        (reset),
                .clk_en       (clk_en),
                .data         (wide_data_reg[w]),
                .drive_sel_lo (wide_sel_lo_reg[w]),
                .drive_sel_hi (wide_sel_hi_reg[w]),
                .ctrl         (wide_port_ctrl[w])
            );
            assign wide_port_pins_out[w]  = wide_port_ctrl[w].pin_out;
            assign wide_port_pins_oe_n[w] = wide_port_ctrl[w].pin_oe_n;
        end
    endgenerate

    genvar n;
    generate
        for (n = 0; n < NARROW_W; n++)
        begin : g_narrow
            gpio_pin_drive u_drive (
                .ref_clk      (ref_clk),
                .reset        (reset),
                .clk_en       (clk_en),
                .data         (narrow_data_reg[n]),
                .drive_sel_lo (narrow_sel_lo_reg[n]),
                .drive_sel_hi (narrow_sel_hi_reg[n]),
                .ctrl         (narrow_port_ctrl[n])
            );
            assign narrow_port_pins_out[n]  = narrow_port_ctrl[n].pin_out;
            assign narrow_port_pins_oe_n[n] = narrow_port_ctrl[n].pin_oe_n;
        end
    endgenerate

endmodule

// ==== common/gpio_pkg.sv ====
// gpio_pkg: register map, fields, resets and pin-control carrier.
// assumes apb, 32-bit data, one register per aligned word.
package gpio_pkg;

    // register indices; the byte address on apb is four times the index
    localparam logic [7:0] WIDE_DATA_IDX    = 8'h00;
    localparam logic [7:0] NARROW_DATA_IDX  = 8'h01;
    localparam logic [7:0] AUX_INPUT_IDX    = 8'h02;
    localparam logic [7:0] WIDE_SEL_LO_IDX  = 8'h0a;
    localparam logic [7:0] WIDE_SEL_HI_IDX  = 8'h0b;
    localparam logic [7:0] NARROW_SEL_LO_IDX = 8'h0c;
    localparam logic [7:0] NARROW_SEL_HI_IDX = 8'h0d;

    // port widths
    localparam int WIDE_PINS   = 8;
    localparam int NARROW_PINS = 2;
    localparam int REG_BITS    = 8;

    // reset values of the written registers
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET  = 8'h00;

    // auxiliary input register bit positions
    localparam int AUX_DPLUS_BIT    = 5;
    localparam int AUX_DMINUS_BIT   = 4;
    localparam int AUX_XTAL_OUT_BIT = 2;
    localparam int AUX_XTAL_IN_BIT  = 1;
    localparam int AUX_REG_PIN_BIT  = 0;
    localparam int AUX_BITS         = 6;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

    // sink strength of the pull-down driver
    typedef enum logic [1:0] {
        SINK_OFF    = 2'b00,
        SINK_LOW    = 2'b01,
        SINK_MEDIUM = 2'b10,
        SINK_HIGH   = 2'b11
    } sink_strength_e;

    // everything the pad needs for one pin
    typedef struct packed {
        logic           pin_out;
        logic           pin_oe_n;
        logic           pullup_driver;
        logic           pulldown_driver;
        sink_strength_e sink_strength;
        logic           pullup_resistor_switch;
        logic           ttl_threshold;
    } pin_ctrl_s;

    localparam pin_ctrl_s PIN_CTRL_RESET = '{
        pin_out: 1'b0, pin_oe_n: 1'b1, pullup_driver: 1'b0,
        pulldown_driver: 1'b0, sink_strength: SINK_OFF,
        pullup_resistor_switch: 1'b0, ttl_threshold: 1'b0
    };

endpackage

// ==== src/pin_level_sync.sv ====
// pin_level_sync: three-flop pin synchroniser.
// assumes async inputs; a change counts once
// stages two and three agree.
`timescale 1ns/1ps
module pin_level_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // stage1 feeds stage2 only; the agreement test uses stages 2 and 3
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                    stage3_reg[i] <= 1'b0;
                    level[i]      <= 1'b0;
                end
                else if (clk_en)
                begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    if (stage2_reg[i] == stage3_reg[i])
                    begin
                        level[i] <= stage3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// ==== src/gpio_pin_drive.sv ====
// gpio_pin_drive: pad controls of one pin.
// assumes registered inputs on ref_clk.
`timescale 1ns/1ps
module gpio_pin_drive (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       data,
    input  wire logic       drive_sel_lo,
    input  wire logic       drive_sel_hi,
    output gpio_pkg::pin_ctrl_s ctrl
);

    gpio_pkg::pin_ctrl_s ctrl_next;

    // decode uses only this pin's own three bits
    always_comb
    begin
        ctrl_next = gpio_pkg::PIN_CTRL_RESET; // hi-z, all drivers off
        if (drive_sel_lo && data)
        begin
            ctrl_next.pullup_driver = 1'b1;
            ctrl_next.pin_out       = 1'b1;
            ctrl_next.pin_oe_n      = 1'b0;
        end
        else if (!drive_sel_lo && drive_sel_hi && data)
        begin
            ctrl_next.pullup_resistor_switch = 1'b1; // weak pull only
        end
        else if ((drive_sel_lo || drive_sel_hi) && !data)
        begin
            ctrl_next.pulldown_driver = 1'b1;
            ctrl_next.pin_oe_n        = 1'b0;
            case ({drive_sel_hi, drive_sel_lo})
                2'b10:   ctrl_next.sink_strength = gpio_pkg::SINK_LOW;
                2'b01:   ctrl_next.sink_strength = gpio_pkg::SINK_MEDIUM;
                2'b11:   ctrl_next.sink_strength = gpio_pkg::SINK_HIGH;
                default: ctrl_next.sink_strength = gpio_pkg::SINK_OFF;
            endcase
        end
        // ttl only in the undriven, data-high case; cmos elsewhere
        ctrl_next.ttl_threshold = !drive_sel_lo && !drive_sel_hi && data;
    end

    // registered so the pad sees glitch-free controls
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl <= gpio_pkg::PIN_CTRL_RESET;
        end
        else if (clk_en)
        begin
            ctrl <= ctrl_next;
        end
    end

endmodule

// ==== verification/board_pins.sv ====
// board_pins: board side of one gpio port.
// assumes pad controls straight from the block.
`timescale 1ns/1ps
module board_pins #(
    parameter int W = 8
) (
    input  wire logic                        ref_clk,
    input  wire logic [W-1:0]                pins_out,
    input  wire logic [W-1:0]                pins_oe_n,
    input  wire gpio_pkg::pin_ctrl_s [W-1:0] ctrl,
    input  wire logic [W-1:0]                ext,
    input  wire logic [W-1:0]                ext_en,
    output logic      [W-1:0]                pins_in
);
    logic [W-1:0] float_reg = '0;

    // an undriven, unpulled pad toggles
    always @(posedge ref_clk)
        float_reg <= ~float_reg;

    // device beats board; resistor only beats a float
    always_comb
        for (int i = 0; i < W; i++)
            pins_in[i] = !pins_oe_n[i] ? pins_out[i] : ext_en[i] ? ext[i]
                : ctrl[i].pullup_resistor_switch ? 1'b1 : float_reg[i];
endmodule

// ==== verification/gpio_ports_with_aux_input_assertions.sv ====
// gpio_checks: apb, pad control and level checks.
// assumes one clock and clk_en high.
`timescale 1ns/1ps
module gpio_checks #(
    parameter int WIDE_W   = 8,
    parameter int NARROW_W = 2
) (
    input wire logic                             ref_clk,
    input wire logic                             reset,
    input wire logic                             clk_en,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [7:0]                       paddr,
    input wire logic [31:0]                      prdata,
    input wire logic                             pslverr,
    input wire logic [WIDE_W-1:0]                wide_port_pins_in,
    input wire logic [WIDE_W-1:0]                wide_port_pins_oe_n,
    input wire gpio_pkg::pin_ctrl_s [WIDE_W-1:0] wide_port_ctrl,
    input wire logic [WIDE_W-1:0]                wide_port_levels,
    input wire logic [NARROW_W-1:0]              narrow_port_levels
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // access decode shared by the bus checks
    wire logic rd_acc = psel && penable && !pwrite;
    wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h28, 8'h2c, 8'h30, 8'h34};

    reset_clear_a: assert property (disable iff (1'b0) reset |=>
        (&wide_port_pins_oe_n) && prdata == 32'h0 && wide_port_levels == '0
        && narrow_port_levels == '0) else $error("reset state");
    ctrl_after_wr_a: assert property ($changed(wide_port_ctrl) |->
        $past(psel && penable && pwrite, 2) || $past(reset) || $past(reset, 2))
        else $error("ctrl moved");
    level_settle_a: assert property ((clk_en && $stable(wide_port_pins_in)) [*6] |->
        wide_port_levels == wide_port_pins_in) else $error("level stale");
    read_level_a: assert property (rd_acc && paddr == 8'h00 |->
        prdata == {24'h0, $past(wide_port_levels)}) else $error("read level");
    bad_addr_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error");
    sel_read_zero_a: assert property (rd_acc && paddr inside {8'h28, 8'h2c, 8'h30, 8'h34}
        |-> prdata == 32'h0) else $error("select readback");
    narrow_rsvd_a: assert property (rd_acc && paddr == 8'h04 |-> prdata[31:2] == 30'h0)
        else $error("narrow reserved");
    aux_rsvd_a: assert property (rd_acc && paddr == 8'h08 |->
        prdata[31:6] == 26'h0 && !prdata[3]) else $error("aux reserved");

    // per-pin consistency of the decoded pad controls
    for (genvar i = 0; i < WIDE_W; i++)
    begin : g_pin
        sink_on_a: assert property (wide_port_ctrl[i].pulldown_driver |->
            !wide_port_ctrl[i].pin_oe_n && !wide_port_ctrl[i].pin_out
            && wide_port_ctrl[i].sink_strength != gpio_pkg::SINK_OFF) else $error("bad sink");
        drive_high_a: assert property (wide_port_ctrl[i].pullup_driver |->
            !wide_port_ctrl[i].pin_oe_n && wide_port_ctrl[i].pin_out
            && !wide_port_ctrl[i].pulldown_driver) else $error("bad high drive");
        resistor_only_a: assert property (wide_port_ctrl[i].pullup_resistor_switch |->
            wide_port_ctrl[i].pin_oe_n && !wide_port_ctrl[i].pullup_driver)
            else $error("resistor");
    end
endmodule

bind gpio_ports_with_aux_input gpio_checks #(.WIDE_W(WIDE_W), .NARROW_W(NARROW_W)) chk (.*);

// ==== verification/tb.sv ====
// tb: self-checking bench for the gpio block.
// assumes package, design and checker compiled first.
`timescale 1ns/1ps
module tb;
    logic                      ref_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0]                paddr, w_in, w_out, w_oe_n, w_lvl, w_ext, w_en, lv;
    logic [31:0]               pwdata, prdata;
    logic [4:0]                aux;
    logic [1:0]                mode, n_in, n_out, n_oe_n, n_lvl, n_ext, n_en;
    gpio_pkg::pin_ctrl_s [7:0] w_ctrl;
    gpio_pkg::pin_ctrl_s [1:0] n_ctrl;
    logic [32:0]               exp_q[$];
    int                        n_mismatch, checks, seed, k;

    gpio_ports_with_aux_input dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wide_port_pins_in(w_in), .wide_port_pins_out(w_out),
        .wide_port_pins_oe_n(w_oe_n), .wide_port_ctrl(w_ctrl), .wide_port_levels(w_lvl),
        .narrow_port_pins_in(n_in), .narrow_port_pins_out(n_out),
        .narrow_port_pins_oe_n(n_oe_n), .narrow_port_ctrl(n_ctrl), .narrow_port_levels(n_lvl),
        .usb_dplus_pin(aux[4]), .usb_dminus_pin(aux[3]), .crystal_out_pin(aux[2]),
        .crystal_in_pin(aux[1]), .regulator_pin(aux[0]), .internal_clock_mode(mode[0]),
        .ps2_mode(mode[1]));
    board_pins #(.W(8)) wide_board (.ref_clk(ref_clk), .pins_out(w_out), .pins_oe_n(w_oe_n),
        .ctrl(w_ctrl), .ext(w_ext), .ext_en(w_en), .pins_in(w_in));
    board_pins #(.W(2)) narrow_board (.ref_clk(ref_clk), .pins_out(n_out),
        .pins_oe_n(n_oe_n), .ctrl(n_ctrl), .ext(n_ext), .ext_en(n_en), .pins_in(n_in));

    // 250 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic stop_test(input bit hung);
        if (hung)
            n_mismatch++;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one apb transfer, then an idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
                stop_test(1'b1);
            @(posedge ref_clk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // expected pad controls of one pin
    function automatic gpio_pkg::pin_ctrl_s dec(input logic lo, input logic hi, input logic d);
        gpio_pkg::pin_ctrl_s c;
        c = gpio_pkg::PIN_CTRL_RESET;
        c.ttl_threshold = !lo && !hi && d;
        if (lo && d)
        begin
            c.pin_out       = 1'b1;
            c.pin_oe_n      = 1'b0;
            c.pullup_driver = 1'b1;
        end
        else if (!d && (lo || hi))
        begin
            c.pin_oe_n        = 1'b0;
            c.pulldown_driver = 1'b1;
            c.sink_strength   = gpio_pkg::sink_strength_e'({lo, hi});
        end
        else if (hi && d)
            c.pullup_resistor_switch = 1'b1;
        return c;
    endfunction

    task automatic cmp_ctrl(input gpio_pkg::pin_ctrl_s e, input gpio_pkg::pin_ctrl_s g);
        if (e.pin_oe_n)
            g.pin_out = e.pin_out; // pad value means nothing while undriven
        chk("pin control", {25'h0, e}, {25'h0, g});
    endtask

    task automatic chk_reset();
        for (int i = 0; i < 8; i++)
            chk("wide reset", {25'h0, gpio_pkg::PIN_CTRL_RESET}, {25'h0, w_ctrl[i]});
        chk("narrow reset", {17'h0, {2{gpio_pkg::PIN_CTRL_RESET}}}, {17'h0, n_ctrl});
        chk("pad enables", 33'h3ff, {23'h0, n_oe_n, w_oe_n});
    endtask

    // program wide pins, compare controls, levels, read
    task automatic drive_case(input logic [7:0] d, input logic [7:0] lo, input logic [7:0] hi);
        gpio_pkg::pin_ctrl_s e;
        w_ext <= 8'($random(seed));
        w_en  <= ~(hi & ~lo);
        apb(1'b1, 8'h28, {24'h0, lo});
        apb(1'b1, 8'h2c, {24'h0, hi});
        apb(1'b1, 8'h00, {24'h0, d});
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            e = dec(lo[i], hi[i], d[i]);
            cmp_ctrl(e, w_ctrl[i]);
            chk("pad enable", {32'h0, e.pin_oe_n}, {32'h0, w_oe_n[i]});
            lv[i] = !e.pin_oe_n ? e.pin_out : w_en[i] ? w_ext[i] : 1'b1;
        end
        chk("levels", {25'h0, lv}, {25'h0, w_lvl});
        rd(8'h00, {25'h0, lv});
    endtask

    // read monitor: pops the oldest expectation
    always @(posedge ref_clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (exp_q.size() == 0)
                chk("stray read", 33'h0, 33'h1);
            else
                chk("read data", exp_q.pop_front(), {pslverr, prdata});
        end

    // main sequence
    initial
    begin
        seed = 70416;
        {reset, clk_en, psel, penable, pwrite} = 5'h18;
        {paddr, pwdata, aux, mode} = '0;
        {w_ext, w_en, n_ext, n_en} = 20'h00ff3;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk_reset();
        w_ext <= 8'h3c;
        repeat (8) @(posedge ref_clk);
        rd(8'h00, {25'h0, 8'h3c});
        for (k = 0; k < 4; k++)
            rd(8'h28 + 8'(4 * k), 33'h0);
        $display("test reset done");
        drive_case(8'haa, 8'hcc, 8'hf0);
        for (k = 0; k < 4; k++)
            drive_case(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
        drive_case(8'h00, 8'h5a, 8'h00);
        drive_case(8'h00, 8'ha5, 8'h00);
        $display("test drive decode done");
        n_ext <= 2'b10;
        apb(1'b1, 8'h30, 32'hffff_fffd);
        apb(1'b1, 8'h34, 32'h0000_00fc);
        apb(1'b1, 8'h04, 32'hffff_ffff);
        repeat (8) @(posedge ref_clk);
        cmp_ctrl(dec(1'b1, 1'b0, 1'b1), n_ctrl[0]);
        cmp_ctrl(dec(1'b0, 1'b0, 1'b1), n_ctrl[1]);
        rd(8'h04, 33'h3);
        $display("test narrow port done");
        apb(1'b1, 8'h08, 32'h0000_00ff);
        for (k = 0; k < 4; k++)
        begin
            aux  <= 5'($random(seed));
            mode <= 2'(k);
            repeat (8) @(posedge ref_clk);
            lv = {2'b0, aux[4:3], 1'b0, aux[2:1] & {2{mode[0]}}, aux[0] & mode[1]};
            rd(8'h08, {25'h0, lv});
        end
        $display("test aux port done");
        rd(8'h3c, {1'b1, 32'h0});
        rd(8'h05, {1'b1, 32'h0});
        $display("test refused access done");
        drive_case(8'hff, 8'hff, 8'h00);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk_reset();
        $display("test reset mid-run done");
        stop_test(1'b0);
    end
endmodule
